// ==== unsigned_field_move_op_defines.vh ====
`ifndef FIELD_MOVE_DEFINES_VH
`define FIELD_MOVE_DEFINES_VH

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_MASK 8'h08
`define REG_RESULT_LO 8'h0c
`define REG_RESULT_HI 8'h10
`define REG_ALIAS 8'h14

// Control fields
`define CTRL_DATA_INDEP_BIT 0
`define CTRL_RESET 32'h0000_0000

// Status and mask bits
`define ST_DONE 0
`define ST_UNDEF 1
`define ST_WIDTH 2

// Alias codes
`define ALIAS_NONE 3'h0
`define ALIAS_LSL 3'h1
`define ALIAS_LSR 3'h2
`define ALIAS_INSZ 3'h3
`define ALIAS_EXTR 3'h4
`define ALIAS_BYTE_EXT 3'h5
`define ALIAS_HALF_EXT 3'h6

// Instruction word fields
`define F_WIDTH_SEL 31
`define F_MASK_SIZE 22
`define F_ROT_HI 21
`define F_ROT_LO 16
`define F_TOP_HI 15
`define F_TOP_LO 10
`define F_SRC_HI 9
`define F_SRC_LO 5
`define F_DST_HI 4
`define F_DST_LO 0

// Single-cycle datapath latency
`define EXEC_TIME_NS 4
`define CLK_PERIOD_NS 4
`define EXEC_CYCLES (`EXEC_TIME_NS / `CLK_PERIOD_NS)

`endif

// ==== unsigned_bitfield_move.v ====
// Functional notes
// - With top-bit at least rotate, source bits rotate..top land at bit 0.
// - With top-bit below rotate, low top+1 bits land at size minus rotate.
// - All result bits outside the moved field are forced to zero.
// - Width and mask-size both one select 64-bit, both zero select 32-bit.
// - Mismatched width/mask-size, or 32-bit with field bit 5 set, is undefined.
// - Operand size is 32 shifted left by the width-select bit.
// - Result is rotated source ANDed with window mask, then with low mask.
// - Rotate field is a right rotate of 0..31 or 0..63 by size.
// - Top-bit field is the leftmost source bit moved, 0..31 or 0..63.
// - Source comes from the source register index, result to destination.
// - Insert-in-zeros uses rotate = -start mod size and top = width-1.
// - Insert start is 0..size-1 and width is 1..size-start.
// - 32-bit top not 011111 and equal to rotate minus one is a left shift.
// - Rotate 0 with top 000111 is byte, with 001111 halfword, zero-extend.
// - With data-independent timing, latency never depends on data or flags.
//
// Added by the designer: the AHB-Lite interface to the registers and the placing of the registers.
`include "unsigned_field_move_op_defines.vh"

module unsigned_bitfield_move (
  input wire clk_i,
  input wire arst_n_i,
  input wire issue_valid_i,
  input wire [31:0] instr_i,
  input wire [63:0] src_data_i,
  input wire [3:0] condition_flags_i,
  input wire haddr_sel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output wire [31:0] hrdata_o,
  output wire hreadyout_o,
  output wire hresp_o,
  output wire [4:0] src_reg_idx_o,
  output reg wb_valid_o,
  output reg [4:0] wb_reg_idx_o,
  output reg [63:0] wb_data_o,
  output reg undef_o,
  output reg [2:0] alias_o,
  output wire irq_o
);

  // Instruction word fields
  wire width_select_bit;
  wire mask_size_bit;
  wire [5:0] rot_field;
  wire [5:0] top_field;
  wire [4:0] src_field;
  wire [4:0] dest_field;

  assign width_select_bit = instr_i[`F_WIDTH_SEL];
  assign mask_size_bit = instr_i[`F_MASK_SIZE];
  assign rot_field = instr_i[`F_ROT_HI:`F_ROT_LO];
  assign top_field = instr_i[`F_TOP_HI:`F_TOP_LO];
  assign src_field = instr_i[`F_SRC_HI:`F_SRC_LO];
  assign dest_field = instr_i[`F_DST_HI:`F_DST_LO];

  assign src_reg_idx_o = src_field;

  wire [6:0] datasize;
  assign datasize = 7'h20 << width_select_bit;

  wire is64;
  assign is64 = width_select_bit & mask_size_bit;

  wire undef_wide;
  wire undef_narrow;
  wire undef;
  assign undef_wide = width_select_bit & ~mask_size_bit;
  assign undef_narrow = ~width_select_bit &
    (mask_size_bit | rot_field[5] | top_field[5]);
  assign undef = undef_wide | undef_narrow;

  wire [5:0] r;
  assign r = is64 ? rot_field : {1'b0, rot_field[4:0]};

  wire [5:0] s;
  assign s = is64 ? top_field : {1'b0, top_field[4:0]};

  // Field wraps past the top when s is below r
  wire wraps;
  wire [5:0] span;
  assign wraps = s < r;
  assign span = s - r;

  // Upper word ignored in 32-bit mode
  wire [63:0] src_used;
  assign src_used = is64 ? src_data_i : {32'h0000_0000, src_data_i[31:0]};

  wire [63:0] rot;
  wire [63:0] tmask;
  wire [63:0] wmask;
  wire [63:0] lowmask;
  wire [63:0] bot;
  wire [63:0] result;

  // One slice per result bit; no barrel shifter, so the
  // depth is the same for every rotate amount
  genvar gi;
  generate
    for (gi = 0; gi < 64; gi = gi + 1) begin : g_bit
      localparam [6:0] bit_pos = gi;
      wire [6:0] src_sum;
      wire [5:0] idx64;
      wire [4:0] idx32;

      assign src_sum = bit_pos + {1'b0, r};
      assign idx64 = src_sum[5:0];
      assign idx32 = src_sum[4:0];

      // top mask covers bits 0..s of the operand
      assign tmask[gi] = (bit_pos <= {1'b0, s}) && (bit_pos < datasize);

      // right rotate injects at the operand's top bit
      if (gi < 32) begin : g_low
        assign rot[gi] = is64 ? src_used[idx64] : src_used[idx32];
        assign wmask[gi] = is64 ? tmask[idx64] : tmask[idx32];
      end else begin : g_high
        assign rot[gi] = is64 & src_used[idx64];
        assign wmask[gi] = is64 & tmask[idx64];
      end

      // unwrapped field keeps only bits 0..s-r
      assign lowmask[gi] = wraps | (bit_pos <= {1'b0, span});

      // wrapped field lands at size minus r
      assign bot[gi] = rot[gi] & wmask[gi];

      // everything outside the field is zero
      assign result[gi] = bot[gi] & lowmask[gi];
    end
  endgenerate

  wire is_byte_ext;
  wire is_half_ext;
  assign is_byte_ext = (rot_field == 6'h00) && (top_field == 6'h07);
  assign is_half_ext = (rot_field == 6'h00) && (top_field == 6'h0f);

  wire [5:0] top_plus_one;
  wire lsl_32;
  wire lsl_64;
  assign top_plus_one = top_field + 6'h01;
  assign lsl_32 = !is64 && (top_field != 6'h1f) &&
    (top_plus_one == rot_field);
  assign lsl_64 = is64 && (top_field != 6'h3f) &&
    (top_plus_one == rot_field);

  // Right shift by immediate
  wire is_lsr;
  assign is_lsr = top_field == (is64 ? 6'h3f : 6'h1f);

  // insert-in-zeros when top field is below rotate
  wire is_insz;
  assign is_insz = top_field < rot_field;

  reg [2:0] alias_d;
  always @* begin
    if (is_byte_ext) begin
      alias_d = `ALIAS_BYTE_EXT;
    end else if (is_half_ext) begin
      alias_d = `ALIAS_HALF_EXT;
    end else if (lsl_32 || lsl_64) begin
      alias_d = `ALIAS_LSL;
    end else if (is_lsr) begin
      alias_d = `ALIAS_LSR;
    end else if (is_insz) begin
      alias_d = `ALIAS_INSZ;
    end else begin
      alias_d = `ALIAS_EXTR;
    end
  end

  // Bus address phase
  reg ap_valid_q;
  reg ap_write_q;
  reg [7:0] ap_addr_q;
  wire word_size;
  wire ap_take;

  // Only whole-word transfers are honoured
  assign word_size = hsize_i == 3'h2;
  assign ap_take = haddr_sel_i & htrans_i[1] & hready_i & word_size;

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ap_valid_q <= 1'b0;
    end else if (hready_i) begin
      ap_valid_q <= ap_take;
    end
  end

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ap_write_q <= 1'b0;
    end else if (hready_i) begin
      ap_write_q <= hwrite_i;
    end
  end

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ap_addr_q <= 8'h00;
    end else if (hready_i) begin
      ap_addr_q <= haddr_i[7:0];
    end
  end

  // Data phase write strobes
  wire wr;
  wire wr_ctrl;
  wire wr_status;
  wire wr_mask;
  assign wr = ap_valid_q & ap_write_q;
  assign wr_ctrl = wr && (ap_addr_q == `REG_CTRL);
  assign wr_status = wr && (ap_addr_q == `REG_STATUS);
  assign wr_mask = wr && (ap_addr_q == `REG_MASK);

  // Control register
  reg [31:0] ctrl_q;
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_q <= `CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= {31'h0, hwdata_i[`CTRL_DATA_INDEP_BIT]};
    end
  end

  // Interrupt mask
  reg [2:0] mask_q;
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mask_q <= 3'h0;
    end else if (wr_mask) begin
      mask_q <= hwdata_i[2:0];
    end
  end

  // Status events
  wire [2:0] ev;
  wire [2:0] w1c;
  wire [2:0] status_d;
  reg [2:0] status_q;
  assign ev[`ST_DONE] = issue_valid_i;
  assign ev[`ST_UNDEF] = issue_valid_i & undef;
  assign ev[`ST_WIDTH] = issue_valid_i & is64 & ~undef;
  assign w1c = wr_status ? hwdata_i[2:0] : 3'h0;

  genvar gj;
  generate
    for (gj = 0; gj < 3; gj = gj + 1) begin : g_status
      // Set wins over clear so no event is lost to a clear
      assign status_d[gj] = ev[gj] | (status_q[gj] & ~w1c[gj]);
    end
  endgenerate

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      status_q <= 3'h0;
    end else begin
      status_q <= status_d;
    end
  end

  // Pending unmasked events
  wire [2:0] pending;
  assign pending = status_q & mask_q;
  assign irq_o = |pending;

  // Write-back stage
  reg [63:0] last_q;

  // fixed one-cycle latency regardless of data or flags
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wb_valid_o <= 1'b0;
    end else begin
      wb_valid_o <= issue_valid_i & ~undef;
    end
  end

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      undef_o <= 1'b0;
    end else begin
      undef_o <= issue_valid_i & undef;
    end
  end

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wb_reg_idx_o <= 5'h00;
    end else if (issue_valid_i) begin
      wb_reg_idx_o <= dest_field;
    end
  end

  // Undefined issue leaves zeros behind
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wb_data_o <= 64'h0;
    end else if (issue_valid_i) begin
      wb_data_o <= undef ? 64'h0 : result;
    end
  end

  // Kept for software readback
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      last_q <= 64'h0;
    end else if (issue_valid_i) begin
      last_q <= undef ? 64'h0 : result;
    end
  end

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      alias_o <= `ALIAS_NONE;
    end else if (issue_valid_i) begin
      alias_o <= undef ? `ALIAS_NONE : alias_d;
    end
  end

  wire [31:0] result_lo;
  wire [31:0] result_hi;
  assign result_lo = last_q[31:0];
  assign result_hi = last_q[63:32];

  // Register read mux, valid in the data phase
  reg [31:0] rdata;
  always @* begin
    case (ap_addr_q)
      `REG_CTRL: begin
        rdata = ctrl_q;
      end
      `REG_STATUS: begin
        rdata = {29'h0, status_q};
      end
      `REG_MASK: begin
        rdata = {29'h0, mask_q};
      end
      `REG_RESULT_LO: begin
        rdata = result_lo;
      end
      `REG_RESULT_HI: begin
        rdata = result_hi;
      end
      `REG_ALIAS: begin
        rdata = {29'h0, alias_o};
      end
      default: begin
        rdata = 32'h0000_0000;
      end
    endcase
  end

  assign hrdata_o = rdata;
  // Zero-wait slave, always OKAY
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

endmodule // unsigned_bitfield_move

// ==== unsigned_field_move_op_checker.sv ====
module field_move_checker (
  input logic clk_i,
  input logic arst_n_i,
  input logic issue_valid_i,
  input logic [31:0] instr_i,
  input logic [63:0] src_data_i,
  input logic [4:0] src_reg_idx_o,
  input logic wb_valid_o,
  input logic undef_o,
  input logic [4:0] wb_reg_idx_o,
  input logic [63:0] wb_data_o,
  input logic [2:0] alias_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  wire ok = instr_i[31] == instr_i[22] &&
    (instr_i[31] || !(instr_i[21] | instr_i[15]));
  wire go = issue_valid_i && ok;
  a_src_index: assert property (
    src_reg_idx_o == instr_i[9:5]) else $error("bad source index");
  a_wb_pulse: assert property (
    go |=> wb_valid_o && !undef_o) else $error("no write-back");
  a_undef_flag: assert property (
    issue_valid_i && !ok |=> undef_o && !wb_valid_o) else $error("no undef");
  a_idle_quiet: assert property (
    !issue_valid_i |=> !wb_valid_o && !undef_o) else $error("stray pulse");
  a_dest_idx: assert property (
    go |=> wb_reg_idx_o == $past(instr_i[4:0])) else $error("bad dest");
  a_upper_zero: assert property (
    go && !instr_i[31] |=> wb_data_o[63:32] == 32'h0) else $error("upper");
  a_byte_ext: assert property (
    go && instr_i[21:10] == 12'h007 |=> alias_o == 3'h5 &&
    wb_data_o == {56'h0, $past(src_data_i[7:0])}) else $error("byte ext");
  a_half_ext: assert property (
    go && instr_i[21:10] == 12'h00f |=> alias_o == 3'h6 &&
    wb_data_o == {48'h0, $past(src_data_i[15:0])}) else $error("half ext");
  a_right_shift: assert property (
    go && !instr_i[31] && instr_i[15:10] == 6'h1f |=> alias_o == 3'h2 &&
    wb_data_o[31:0] == $past(src_data_i[31:0]) >> $past(instr_i[20:16]))
    else $error("right shift");
endmodule // field_move_checker

// ==== regfile_model.sv ====
module regfile_model (
  input logic clk_i,
  input logic [4:0] rd_idx_i,
  output logic [63:0] rd_data_o,
  input logic wr_en_i,
  input logic [4:0] wr_idx_i,
  input logic [63:0] wr_data_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] rf [32];
  initial foreach (rf[i]) rf[i] = 64'h9e37_79b9_7f4a_7c15 * (i + 1);
  assign rd_data_o = rf[rd_idx_i];
  always @(posedge clk_i) if (wr_en_i) rf[wr_idx_i] <= wr_data_i;
endmodule // regfile_model

// ==== testbench.sv ====
`include "unsigned_field_move_op_defines.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, arst_n_i = 0, issue_valid_i = 0, hsel = 0, hwrite = 0;
  logic [31:0] instr_i = 0, haddr = 0, hwdata = 0, hrdata, rd, w;
  logic [1:0] htrans = 0;
  logic [3:0] flags = 0;
  logic [63:0] src, wb_data, ed;
  logic [4:0] src_idx, wb_idx, ei;
  logic wb_valid, undef, irq, hready, hresp, ev = 0, eu;
  int mismatches = 0, cmp_count = 0, cyc = 0, n, lsb;
  unsigned_bitfield_move unsigned_bitfield_move_inst (.clk_i(clk_i),
    .arst_n_i(arst_n_i), .issue_valid_i(issue_valid_i), .instr_i(instr_i),
    .src_data_i(src), .condition_flags_i(flags), .haddr_sel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .src_reg_idx_o(src_idx),
    .wb_valid_o(wb_valid), .wb_reg_idx_o(wb_idx), .wb_data_o(wb_data),
    .undef_o(undef), .alias_o(), .irq_o(irq));
  regfile_model regfile_model_inst (.clk_i(clk_i), .rd_idx_i(src_idx),
    .rd_data_o(src), .wr_en_i(wb_valid), .wr_idx_i(wb_idx),
    .wr_data_i(wb_data));
  initial forever #2 clk_i = ~clk_i;
  task results;
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      results();
    end
  end
  task chk(string nm, logic [63:0] e, logic [63:0] s);
    cmp_count++;
    if (e !== s) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task ahb(input logic wr, input logic [31:0] a, d, output logic [31:0] q);
    @(posedge clk_i);
    hsel <= 1; htrans <= 2'h2; hwrite <= wr; haddr <= a;
    do @(posedge clk_i); while (hready !== 1'b1);
    htrans <= 2'h0; hsel <= 0; hwdata <= d;
    do @(posedge clk_i); while (hready !== 1'b1);
    q = hrdata;
  endtask
  function logic [63:0] model(logic [31:0] x, logic [63:0] s);
    int r, t;
    logic [63:0] v;
    r = x[21:16];
    t = x[15:10];
    if (!x[31]) s[63:32] = 0;
    v = (s >> r) | (s << (n - r));
    if (t >= r) v &= (64'h1 << (t - r + 1)) - 1;
    else v &= ((64'h1 << (t + 1)) - 1) << (n - r);
    return x[31] ? v : v & 64'hffff_ffff;
  endfunction
  initial begin
    void'($urandom(32'h57ac));
    repeat (16) @(posedge clk_i);
    arst_n_i <= 1;
    ahb(0, `REG_CTRL, 0, rd);
    chk("ctrl reset", `CTRL_RESET, rd);
    ahb(1, `REG_CTRL, 1, rd);
    ahb(0, `REG_CTRL, 0, rd);
    chk("ctrl readback", 1, rd);
    chk("hresp", 0, hresp);
    $display("test done: registers");
    for (int i = 0; i < 401; i++) begin
      @(posedge clk_i);
      w = $urandom;
      w[30:23] = 8'ha6;
      n = w[31] ? 64 : 32;
      if (i % 8) begin
        w[22] = w[31];
        if (!w[31]) {w[21], w[15]} = 2'h0;
      end
      if (i % 8 == 2) w[21:10] = 12'h007;
      if (i % 8 == 3) w[21:10] = 12'h00f;
      if (i % 8 == 4) begin
        lsb = $urandom % n;
        w[21:16] = (n - lsb) % n;
        w[15:10] = $urandom % (n - lsb);
      end
      if (i % 8 == 5) w[15:10] = (w[21:16] | 6'h1) - 1;
      if (i % 8 == 5) w[21:16] = w[21:16] | 6'h1;
      if (i % 8 == 6) w[15:10] = w[31] ? 6'h3f : 6'h1f;
      issue_valid_i <= (i < 400) && ($urandom % 4 != 0);
      instr_i <= w;
      flags <= $urandom;
      #1;
      chk("wb_valid", ev && !eu, wb_valid);
      chk("undef", ev && eu, undef);
      if (ev && !eu) chk("wb_data", ed, wb_data);
      if (ev && !eu) chk("wb_idx", ei, wb_idx);
      ev = issue_valid_i;
      eu = !(w[31] == w[22] && (w[31] || !(w[21] | w[15])));
      ed = model(w, regfile_model_inst.rf[w[9:5]]);
      ei = w[4:0];
    end
    $display("test done: random issue");
    ahb(1, `REG_MASK, 0, rd);
    @(posedge clk_i);
    chk("irq masked", 0, irq);
    ahb(1, `REG_MASK, 32'h3, rd);
    @(posedge clk_i);
    chk("irq raised", 1, irq);
    ahb(1, `REG_STATUS, 32'h7, rd);
    @(posedge clk_i);
    chk("irq cleared", 0, irq);
    ahb(0, `REG_STATUS, 0, rd);
    chk("status", 0, rd);
    ahb(0, 32'h40, 0, rd);
    chk("unmapped", 0, rd);
    $display("test done: interrupt");
    n = 32;
    w = {1'b0, 8'ha6, 1'b0, 6'h00, 6'h07, 5'h03, 5'h04};
    ed = {56'h0, regfile_model_inst.rf[3][7:0]};
    instr_i <= w;
    issue_valid_i <= 1;
    @(posedge clk_i);
    issue_valid_i <= 0;
    ahb(0, `REG_RESULT_LO, 0, rd);
    chk("result lo", ed[31:0], rd);
    ahb(0, `REG_ALIAS, 0, rd);
    chk("alias", `ALIAS_BYTE_EXT, rd);
    $display("test done: readback");
    results();
  end
endmodule // testbench
bind unsigned_bitfield_move field_move_checker field_move_checker_inst (.*);
